// >>> dcw_params.svh
// Constants for the display-on and column-window command logic.
`ifndef DCW_PARAMS_SVH
`define DCW_PARAMS_SVH
`define DCW_CMD_DISPLAY_ON   8'h29
`define DCW_CMD_COLUMN_SET   8'h2A
`define DCW_CMD_MEM_WRITE    8'h2C
`define DCW_COL_START_RESET  16'h0000
`define DCW_COL_LAST_NORMAL  16'h00EF
`define DCW_COL_LAST_EXCH    16'h013F
`define DCW_PAGE_START_RESET 16'h0000
`define DCW_CLK_PERIOD_NS    4
`define DCW_WR_LOW_NS        16
`define DCW_WR_HIGH_NS       16
`define DCW_WR_LOW_CYC  (((`DCW_WR_LOW_NS) + (`DCW_CLK_PERIOD_NS) - 1) / (`DCW_CLK_PERIOD_NS))
`define DCW_WR_HIGH_CYC (((`DCW_WR_HIGH_NS) + (`DCW_CLK_PERIOD_NS) - 1) / (`DCW_CLK_PERIOD_NS))
`endif

// >>> dcw_pkg.sv
// Types shared by both ends of the command bus.
package dcw_pkg;
   typedef enum logic [1:0] {
      DCW_OP_DISPLAY_ON,
      DCW_OP_COLUMN_WINDOW,
      DCW_OP_MEM_WRITE,
      DCW_OP_MEM_DATA
   } dcw_op_e;

   typedef enum logic [1:0] {
      DCW_PS_IDLE,
      DCW_PS_COLUMN,
      DCW_PS_MEM_WRITE
   } dcw_parse_e;

   typedef enum logic [1:0] {
      DCW_HS_IDLE,
      DCW_HS_LOW,
      DCW_HS_HIGH
   } dcw_hstate_e;

   typedef logic [15:0] dcw_col_t;
   typedef logic [17:0] dcw_word_t;
endpackage

// >>> dcw_bus_if.sv
// Parallel strobed command bus between host and display driver.
`timescale 1ns/1ps
interface dcw_bus_if;
   logic        data_command_select;
   logic        write_strobe;
   logic        read_strobe;
   logic [17:0] data;

   modport host (
      output data_command_select,
      output write_strobe,
      output read_strobe,
      output data
   );

   modport device (
      input  data_command_select,
      input  write_strobe,
      input  read_strobe,
      input  data
   );
endinterface // dcw_bus_if

// >>> dcw_device.sv
// Driver end: command decode, display on flag, column window and write pointers.
`timescale 1ns/1ps
`include "dcw_params.svh"
module dcw_device (
   input  wire logic              mclk,
   input  wire logic              reset,
   dcw_bus_if.device              bus,
   input  wire logic              soft_reset,
   input  wire logic              exchange_bit,
   input  wire dcw_pkg::dcw_col_t start_page,
   input  wire dcw_pkg::dcw_word_t frame_pixel,
   output logic                   display_on,
   output dcw_pkg::dcw_word_t     panel_pixel,
   output dcw_pkg::dcw_col_t      start_column,
   output dcw_pkg::dcw_col_t      end_column,
   output logic                   mem_we,
   output dcw_pkg::dcw_col_t      mem_col,
   output dcw_pkg::dcw_col_t      mem_page,
   output dcw_pkg::dcw_word_t     mem_data
);
   import dcw_pkg::*;

   logic        dcx_s1_ff;
   logic        dcx_s2_ff;
   logic        wr_s1_ff;
   logic        wr_s2_ff;
   logic        wr_s3_ff;
   dcw_word_t   dat_s1_ff;
   dcw_word_t   dat_s2_ff;
   logic        wr_rise;
   logic        is_cmd;
   logic        is_param;
   logic [7:0]  byte_in;

   dcw_parse_e  parse_ff;
   logic [1:0]  pidx_ff;
   logic [7:0]  sc_hi_ff;
   logic [7:0]  sc_lo_ff;
   logic [7:0]  ec_hi_ff;
   logic        display_on_ff;
   dcw_col_t    start_column_ff;
   dcw_col_t    end_column_ff;
   dcw_col_t    col_ptr_ff;
   dcw_col_t    page_ptr_ff;
   logic        mem_we_ff;
   dcw_col_t    mem_col_ff;
   dcw_col_t    mem_page_ff;
   dcw_word_t   mem_data_ff;
   dcw_word_t   panel_pixel_ff;
   dcw_col_t    col_limit;
   logic        col_valid;

   // The strobe, select and data lines come from another chip, so select and data pass two flops and the strobe three.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         dcx_s1_ff <= 1'b1;
         dcx_s2_ff <= 1'b1;
         wr_s1_ff  <= 1'b1;
         wr_s2_ff  <= 1'b1;
         wr_s3_ff  <= 1'b1;
         dat_s1_ff <= 18'h0_0000;
         dat_s2_ff <= 18'h0_0000;
      end else begin
         dcx_s1_ff <= bus.data_command_select;
         dcx_s2_ff <= dcx_s1_ff;
         wr_s1_ff  <= bus.write_strobe;
         wr_s2_ff  <= wr_s1_ff;
         wr_s3_ff  <= wr_s2_ff;
         dat_s1_ff <= bus.data;
         dat_s2_ff <= dat_s1_ff;
      end
   end

   // Data and select are synchronised with the same latency as the strobe, so the host
   // must hold them stable across the whole low phase and the following high phase.
   assign wr_rise  = wr_s2_ff & ~wr_s3_ff;
   assign is_cmd   = wr_rise & ~dcx_s2_ff;
   assign is_param = wr_rise & dcx_s2_ff;
   assign byte_in  = dat_s2_ff[7:0];

   // The limit follows the live orientation, so flipping exchange_bit mid-frame moves the cut.
   assign col_limit = exchange_bit ? `DCW_COL_LAST_EXCH : `DCW_COL_LAST_NORMAL;
   assign col_valid = (col_ptr_ff <= col_limit);

   // Command parser; any command other than the two parameter-taking ones ends a sequence.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         parse_ff <= DCW_PS_IDLE;
         pidx_ff  <= 2'h0;
      end else if (soft_reset) begin
         parse_ff <= DCW_PS_IDLE;
         pidx_ff  <= 2'h0;
      end else if (is_cmd) begin
         pidx_ff <= 2'h0;
         case (byte_in)
            `DCW_CMD_COLUMN_SET: parse_ff <= DCW_PS_COLUMN;
            `DCW_CMD_MEM_WRITE:  parse_ff <= DCW_PS_MEM_WRITE;
            default:             parse_ff <= DCW_PS_IDLE;
         endcase
      end else if (is_param) begin
         case (parse_ff)
            DCW_PS_COLUMN: begin
               pidx_ff <= pidx_ff + 2'h1;
               if (pidx_ff == 2'h3) begin
                  parse_ff <= DCW_PS_IDLE;
               end
            end
            DCW_PS_MEM_WRITE: parse_ff <= DCW_PS_MEM_WRITE;
            default:          parse_ff <= DCW_PS_IDLE;
         endcase
      end
   end

   // Display on sets only this flag; a repeat is harmless because the flag is already set.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         display_on_ff <= 1'b0;
      end else if (soft_reset) begin
         display_on_ff <= 1'b0;
      end else if (is_cmd && byte_in == `DCW_CMD_DISPLAY_ON) begin
         display_on_ff <= 1'b1;
      end
   end

   // Blank page while off, frame memory contents while on.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         panel_pixel_ff <= 18'h0_0000;
      end else begin
         panel_pixel_ff <= display_on_ff ? frame_pixel : 18'h0_0000;
      end
   end

   // Bounds change only after the fourth byte, so a short sequence leaves the old window.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         sc_hi_ff        <= 8'h00;
         sc_lo_ff        <= 8'h00;
         ec_hi_ff        <= 8'h00;
         start_column_ff <= `DCW_COL_START_RESET;
         end_column_ff   <= `DCW_COL_LAST_NORMAL;
      end else if (soft_reset) begin
         start_column_ff <= `DCW_COL_START_RESET;
         end_column_ff   <= exchange_bit ? `DCW_COL_LAST_EXCH : `DCW_COL_LAST_NORMAL;
      end else if (is_param && parse_ff == DCW_PS_COLUMN) begin
         case (pidx_ff)
            2'h0: sc_hi_ff <= byte_in;
            2'h1: sc_lo_ff <= byte_in;
            2'h2: ec_hi_ff <= byte_in;
            default: begin
               start_column_ff <= {sc_hi_ff, sc_lo_ff};
               end_column_ff   <= {ec_hi_ff, byte_in};
            end
         endcase
      end
   end

   // Write pointers: reload on the memory write command, advance on every data word.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         col_ptr_ff  <= `DCW_COL_START_RESET;
         page_ptr_ff <= `DCW_PAGE_START_RESET;
      end else if (is_cmd && byte_in == `DCW_CMD_MEM_WRITE) begin
         col_ptr_ff  <= start_column_ff;
         page_ptr_ff <= start_page;
      end else if (is_param && parse_ff == DCW_PS_MEM_WRITE) begin
         // A word at the end column wraps to the start column of the next page.
         if (col_ptr_ff >= end_column_ff) begin
            col_ptr_ff  <= start_column_ff;
            page_ptr_ff <= page_ptr_ff + 16'h0001;
         end else begin
            col_ptr_ff <= col_ptr_ff + 16'h0001;
         end
      end
   end

   // Words that land beyond the last real column are dropped but still advance the pointer.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         mem_we_ff   <= 1'b0;
         mem_col_ff  <= 16'h0000;
         mem_page_ff <= 16'h0000;
         mem_data_ff <= 18'h0_0000;
      end else begin
         mem_we_ff <= is_param && parse_ff == DCW_PS_MEM_WRITE && col_valid;
         if (is_param && parse_ff == DCW_PS_MEM_WRITE) begin
            mem_col_ff  <= col_ptr_ff;
            mem_page_ff <= page_ptr_ff;
            mem_data_ff <= dat_s2_ff;
         end
      end
   end

   // Every output is a flop, so the panel and memory side see no decode glitches.
   assign display_on   = display_on_ff;
   assign panel_pixel  = panel_pixel_ff;
   assign start_column = start_column_ff;
   assign end_column   = end_column_ff;
   assign mem_we       = mem_we_ff;
   assign mem_col      = mem_col_ff;
   assign mem_page     = mem_page_ff;
   assign mem_data     = mem_data_ff;
endmodule // dcw_device

// >>> dcw_host.sv
// Host end: turns user requests into strobed command and parameter writes.
`timescale 1ns/1ps
`include "dcw_params.svh"
module dcw_host #(
   parameter int LOW_CYC  = `DCW_WR_LOW_CYC,
   parameter int HIGH_CYC = `DCW_WR_HIGH_CYC
) (
   input  wire logic               mclk,
   input  wire logic               reset,
   input  wire logic               req_valid,
   input  wire dcw_pkg::dcw_op_e   req_op,
   input  wire dcw_pkg::dcw_col_t  req_start,
   input  wire dcw_pkg::dcw_col_t  req_end,
   input  wire dcw_pkg::dcw_word_t req_data,
   output logic                    req_ready,
   output logic                    req_error,
   dcw_bus_if.host                 bus
);
   import dcw_pkg::*;

   dcw_hstate_e hs_ff;
   dcw_op_e     op_ff;
   dcw_col_t    start_ff;
   dcw_col_t    end_ff;
   dcw_word_t   wdata_ff;
   logic [2:0]  idx_ff;
   logic [2:0]  last_ff;
   logic [7:0]  tmr_ff;
   logic        error_ff;
   logic        dcx_ff;
   logic        wr_ff;
   dcw_word_t   bus_data_ff;
   logic        take;
   logic        bad_window;
   logic        nxt_dcx;
   dcw_word_t   nxt_data;

   assign bad_window = (req_op == DCW_OP_COLUMN_WINDOW) && (req_start > req_end);
   assign req_ready  = (hs_ff == DCW_HS_IDLE);
   assign take       = req_valid && req_ready;

   // Byte to send at step idx_ff of the latched request.
   always_comb begin
      nxt_dcx  = 1'b1;
      nxt_data = 18'h0_0000;
      case (op_ff)
         DCW_OP_DISPLAY_ON: begin
            nxt_dcx  = 1'b0;
            nxt_data = {10'h000, `DCW_CMD_DISPLAY_ON};
         end
         DCW_OP_COLUMN_WINDOW: begin
            case (idx_ff)
               3'h0:    begin
                  nxt_dcx  = 1'b0;
                  nxt_data = {10'h000, `DCW_CMD_COLUMN_SET};
               end
               3'h1:    nxt_data = {10'h000, start_ff[15:8]};
               3'h2:    nxt_data = {10'h000, start_ff[7:0]};
               3'h3:    nxt_data = {10'h000, end_ff[15:8]};
               default: nxt_data = {10'h000, end_ff[7:0]};
            endcase
         end
         DCW_OP_MEM_WRITE: begin
            nxt_dcx  = 1'b0;
            nxt_data = {10'h000, `DCW_CMD_MEM_WRITE};
         end
         default: nxt_data = wdata_ff;
      endcase
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         op_ff    <= DCW_OP_DISPLAY_ON;
         start_ff <= 16'h0000;
         end_ff   <= 16'h0000;
         wdata_ff <= 18'h0_0000;
         last_ff  <= 3'h0;
      end else if (take) begin
         op_ff    <= req_op;
         start_ff <= req_start;
         end_ff   <= req_end;
         wdata_ff <= req_data;
         last_ff  <= (req_op == DCW_OP_COLUMN_WINDOW) ? 3'h4 : 3'h0;
      end
   end

   // A window with start above end is refused and never reaches the bus.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         error_ff <= 1'b0;
      end else begin
         error_ff <= take && bad_window;
      end
   end

   // Strobe sequencer: low phase with data set up, rising edge, high phase holding data.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         hs_ff       <= DCW_HS_IDLE;
         idx_ff      <= 3'h0;
         tmr_ff      <= 8'h00;
         dcx_ff      <= 1'b1;
         wr_ff       <= 1'b1;
         bus_data_ff <= 18'h0_0000;
      end else begin
         case (hs_ff)
            DCW_HS_IDLE: begin
               if (take && !bad_window) begin
                  hs_ff  <= DCW_HS_LOW;
                  idx_ff <= 3'h0;
                  tmr_ff <= 8'h00;
               end
            end
            DCW_HS_LOW: begin
               dcx_ff      <= nxt_dcx;
               bus_data_ff <= nxt_data;
               wr_ff       <= 1'b0;
               if (tmr_ff == 8'(LOW_CYC - 1)) begin
                  hs_ff  <= DCW_HS_HIGH;
                  tmr_ff <= 8'h00;
               end else begin
                  tmr_ff <= tmr_ff + 8'h01;
               end
            end
            DCW_HS_HIGH: begin
               wr_ff <= 1'b1;
               if (tmr_ff == 8'(HIGH_CYC - 1)) begin
                  tmr_ff <= 8'h00;
                  if (idx_ff == last_ff) begin
                     hs_ff <= DCW_HS_IDLE;
                  end else begin
                     idx_ff <= idx_ff + 3'h1;
                     hs_ff  <= DCW_HS_LOW;
                  end
               end else begin
                  tmr_ff <= tmr_ff + 8'h01;
               end
            end
            default: hs_ff <= DCW_HS_IDLE;
         endcase
      end
   end

   assign req_error               = error_ff;
   assign bus.data_command_select = dcx_ff;
   assign bus.write_strobe        = wr_ff;
   assign bus.read_strobe         = 1'b1;
   assign bus.data                = bus_data_ff;
endmodule // dcw_host

// >>> dcw_cmd_props.sv
// Concurrent checks on the command bus and the driver outputs.
`timescale 1ns/1ps
module dcw_cmd_props (
   input wire logic               mclk,
   input wire logic               reset,
   input wire logic               data_command_select,
   input wire logic               write_strobe,
   input wire logic               read_strobe,
   input wire logic [17:0]        data,
   input wire logic               soft_reset,
   input wire logic               exchange_bit,
   input wire dcw_pkg::dcw_word_t frame_pixel,
   input wire logic               display_on,
   input wire dcw_pkg::dcw_word_t panel_pixel,
   input wire dcw_pkg::dcw_col_t  start_column,
   input wire dcw_pkg::dcw_col_t  end_column,
   input wire logic               mem_we,
   input wire dcw_pkg::dcw_col_t  mem_col
);
   import dcw_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   AST_RD_IDLE: assert property (read_strobe) else $error("read strobe left its idle level");
   AST_WR_LOW: assert property ($fell(write_strobe) |-> !write_strobe [*4] ##1 write_strobe)
      else $error("write strobe low phase has the wrong length");
   // The device samples the bus late, so the byte must outlive the rising strobe.
   AST_HOLD: assert property (
      $rose(write_strobe) |-> ($stable(data) && $stable(data_command_select)) [*3])
      else $error("bus byte changed too soon after the strobe rose");
   AST_LOW_STABLE: assert property (!write_strobe && !$fell(write_strobe) |-> $stable(data))
      else $error("bus byte changed while the strobe was low");
   AST_PANEL: assert property (display_on && $past(display_on) |-> panel_pixel == $past(frame_pixel))
      else $error("panel does not follow frame memory while on");
   AST_BLANK: assert property (!display_on && !$past(display_on) |-> panel_pixel == 18'h0_0000)
      else $error("panel not blank while off");
   AST_STICKY: assert property (display_on && !soft_reset |=> display_on)
      else $error("display dropped without a reset");
   AST_ON_KEEPS: assert property ($rose(display_on) |-> $stable(start_column) && $stable(end_column))
      else $error("display on disturbed the column bounds");
   AST_SOFT: assert property (soft_reset |=> !display_on && start_column == 16'h0000 &&
      end_column == ($past(exchange_bit) ? 16'h013F : 16'h00EF)) else $error("soft reset values wrong");
   // The write decision is taken one cycle before the pulse, under the orientation of that cycle.
   AST_RANGE: assert property (mem_we |-> mem_col <= ($past(exchange_bit) ? 16'h013F : 16'h00EF))
      else $error("write outside the valid column range");
   AST_WE_PULSE: assert property (mem_we |=> !mem_we) else $error("write enable longer than one cycle");
endmodule // dcw_cmd_props

// >>> display_on_and_column_window_tb.sv
// Testbench joining host and driver ends over the command bus.
`timescale 1ns/1ps
module display_on_and_column_window_tb;
   import dcw_pkg::*;
   logic      mclk, reset, req_valid, req_ready, req_error, soft_reset, exchange_bit, mem_we, display_on;
   dcw_op_e   req_op;
   dcw_col_t  req_start, req_end, start_page, start_column, end_column, mem_col, mem_page;
   dcw_word_t req_data, frame_pixel, panel_pixel, mem_data;
   logic      err_seen;
   logic [49:0] mq[$];
   int        n_fail, num_checks;
   dcw_bus_if dcw_bus_if_inst ();
   dcw_host #(.LOW_CYC(4), .HIGH_CYC(4)) dcw_host_inst (.mclk(mclk), .reset(reset), .req_valid(req_valid),
      .req_op(req_op), .req_start(req_start), .req_end(req_end), .req_data(req_data), .req_ready(req_ready),
      .req_error(req_error), .bus(dcw_bus_if_inst.host));
   dcw_device dcw_device_inst (.mclk(mclk), .reset(reset), .bus(dcw_bus_if_inst.device), .soft_reset(soft_reset),
      .exchange_bit(exchange_bit), .start_page(start_page), .frame_pixel(frame_pixel), .display_on(display_on),
      .panel_pixel(panel_pixel), .start_column(start_column), .end_column(end_column), .mem_we(mem_we),
      .mem_col(mem_col), .mem_page(mem_page), .mem_data(mem_data));
   dcw_cmd_props dcw_cmd_props_inst (.mclk(mclk), .reset(reset),
      .data_command_select(dcw_bus_if_inst.data_command_select), .write_strobe(dcw_bus_if_inst.write_strobe),
      .read_strobe(dcw_bus_if_inst.read_strobe), .data(dcw_bus_if_inst.data), .soft_reset(soft_reset),
      .exchange_bit(exchange_bit), .frame_pixel(frame_pixel), .display_on(display_on),
      .panel_pixel(panel_pixel), .start_column(start_column), .end_column(end_column), .mem_we(mem_we),
      .mem_col(mem_col));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // Sampled mid-cycle so the one-cycle write pulse is seen settled.
   always @(negedge mclk) begin
      if (mem_we === 1'b1) mq.push_back({mem_col, mem_page, mem_data});
   end
   task automatic finish_test();
      if (n_fail == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One request to the host; returns once the bus is idle and the driver has had time to act.
   task automatic send(input dcw_op_e op, input dcw_col_t s, input dcw_col_t e, input dcw_word_t d);
      int n;
      n = 0;
      @(negedge mclk);
      req_valid = 1'b1;
      req_op = op;
      req_start = s;
      req_end = e;
      req_data = d;
      @(negedge mclk);
      err_seen = req_error;
      req_valid = 1'b0;
      while (req_ready !== 1'b1 && n < 200) begin
         @(negedge mclk);
         n++;
      end
      chk({17'h0_0000, req_ready}, 18'h0_0001);
      repeat (6) @(negedge mclk);
   endtask
   task automatic hard_reset();
      reset = 1'b1;
      repeat (3) @(negedge mclk);
      reset = 1'b0;
   endtask
   task automatic check_bounds(input dcw_col_t s, input dcw_col_t e);
      chk({2'b00, start_column}, {2'b00, s});
      chk({2'b00, end_column}, {2'b00, e});
   endtask
   initial begin
      #40000;
      n_fail++;
      finish_test();
   end
   initial begin
      dcw_col_t col, pg;
      logic [49:0] exp[$];
      {reset, req_valid, soft_reset, err_seen} = 4'b1000;
      {req_start, req_end, start_page} = {16'h0000, 16'h0000, 16'h0005};
      {req_op, req_data, frame_pixel, exchange_bit} = {DCW_OP_DISPLAY_ON, 18'h0_0000, 18'h2_A5C3, 1'b1};
      hard_reset();
      chk({17'h0_0000, display_on}, 18'h0_0000);
      check_bounds(16'h0000, 16'h00EF);
      chk(panel_pixel, 18'h0_0000);
      send(DCW_OP_COLUMN_WINDOW, 16'h0012, 16'h0134, 18'h0_0000);
      check_bounds(16'h0012, 16'h0134);
      chk({17'h0_0000, display_on}, 18'h0_0000);
      send(DCW_OP_DISPLAY_ON, 16'h0000, 16'h0000, 18'h0_0000);
      chk({17'h0_0000, display_on}, 18'h0_0001);
      check_bounds(16'h0012, 16'h0134);
      chk(panel_pixel, frame_pixel);
      frame_pixel = 18'h1_5A3C;
      repeat (2) @(negedge mclk);
      chk(panel_pixel, 18'h1_5A3C);
      send(DCW_OP_DISPLAY_ON, 16'h0000, 16'h0000, 18'h0_0000);
      chk({17'h0_0000, display_on}, 18'h0_0001);
      send(DCW_OP_COLUMN_WINDOW, 16'h0040, 16'h003F, 18'h0_0000);
      chk({17'h0_0000, err_seen}, 18'h0_0001);
      check_bounds(16'h0012, 16'h0134);
      exchange_bit = 1'b0;
      send(DCW_OP_COLUMN_WINDOW, 16'h00EE, 16'h00F0, 18'h0_0000);
      check_bounds(16'h00EE, 16'h00F0);
      chk({17'h0_0000, display_on}, 18'h0_0001);
      mq.delete();
      send(DCW_OP_MEM_WRITE, 16'h0000, 16'h0000, 18'h0_0000);
      col = 16'h00EE;
      pg = start_page;
      for (int i = 0; i < 4; i++) begin
         send(DCW_OP_MEM_DATA, 16'h0000, 16'h0000, 18'h1_0000 + 18'(i));
         // Words past the last valid column are dropped, but the pointer still moves on.
         if (col <= 16'h00EF) exp.push_back({col, pg, 18'h1_0000 + 18'(i)});
         if (col >= 16'h00F0) begin
            col = 16'h00EE;
            pg++;
         end else begin
            col++;
         end
      end
      chk(18'(mq.size()), 18'(exp.size()));
      foreach (exp[i]) begin
         if (i < mq.size()) chk({2'b00, mq[i][49:34]}, {2'b00, exp[i][49:34]});
         if (i < mq.size()) chk({2'b00, mq[i][33:18]}, {2'b00, exp[i][33:18]});
         if (i < mq.size()) chk(mq[i][17:0], exp[i][17:0]);
      end
      for (int x = 1; x >= 0; x--) begin
         exchange_bit = x[0];
         @(negedge mclk);
         soft_reset = 1'b1;
         @(negedge mclk);
         soft_reset = 1'b0;
         chk({17'h0_0000, display_on}, 18'h0_0000);
         check_bounds(16'h0000, x ? 16'h013F : 16'h00EF);
         if (x == 1) begin
            send(DCW_OP_DISPLAY_ON, 16'h0000, 16'h0000, 18'h0_0000);
            chk({17'h0_0000, display_on}, 18'h0_0001);
         end
      end
      exchange_bit = 1'b1;
      soft_reset = 1'b1;
      @(negedge mclk);
      soft_reset = 1'b0;
      send(DCW_OP_DISPLAY_ON, 16'h0000, 16'h0000, 18'h0_0000);
      hard_reset();
      chk({17'h0_0000, display_on}, 18'h0_0000);
      check_bounds(16'h0000, 16'h00EF);
      finish_test();
   end
endmodule // display_on_and_column_window_tb
